/* include/smx_regs.vh */
`ifndef SMX_REGS_VH
`define SMX_REGS_VH
// header-location pointer fields
`define SMX_HLP_VALID_BIT   0
`define SMX_HLP_RSVD_BIT    1
`define SMX_HLP_ADDR_MASK   32'hFFFFFFFC
`define SMX_HLP_RESET       32'h00000000
// config_ctl_one bit positions
`define SMX_CC1_PIN_EN      1
`define SMX_CC1_ACCESS      2
`define SMX_CC1_REG3_SEL    7
// two-byte opcodes, second byte after 0F
`define SMX_OP_PREFIX       8'h0F
`define SMX_OP_SEG_SAVE     8'h78
`define SMX_OP_SEG_REST     8'h79
`define SMX_OP_LDT_SAVE     8'h7A
`define SMX_OP_LDT_REST     8'h7B
`define SMX_OP_TSK_SAVE     8'h7C
`define SMX_OP_TSK_REST     8'h7D
`define SMX_OP_SOFT_ENTRY   8'h38
`define SMX_OP_HDR_READ     8'h36
`define SMX_OP_HDR_WRITE    8'h37
`define SMX_OP_RESUME       8'hAA
// segment register codes in the sreg3 field
`define SMX_SREG_CS         3'h1
`define SMX_SREG_LAST       3'h5
// reset values forced on entry
`define SMX_CR0_RESET       32'h00000010
`define SMX_FLAGS_RESET     32'h00000002
`define SMX_DBG_RESET       32'h00000400
`define SMX_CS_LIMIT        32'hFFFFFFFF
// descriptor transfer width
`define SMX_DESC_BITS       80
// I/O size codes
`define SMX_IO_BYTE         4'h1
`define SMX_IO_WORD         4'h3
`define SMX_IO_DWORD        4'hF
`endif

/* rtl/smx_op_decode.v */
`timescale 1ns/1ns
`include "smx_regs.vh"
// decodes the second byte of a 0F-prefixed management instruction
module smx_op_decode (
    input  wire [7:0] prefixByte,
    input  wire [7:0] opByte,
    output reg  [9:0] opHit
);
    // opHit: 0 segSave 1 segRest 2 ldtSave 3 ldtRest 4 tskSave 5 tskRest
    //        6 softEntry 7 hdrRead 8 hdrWrite 9 resume
    always @* begin
        opHit = 10'h000;
        if (prefixByte == `SMX_OP_PREFIX) begin
            case (opByte)
                `SMX_OP_SEG_SAVE:   opHit = 10'h001; // [RQ10]
                `SMX_OP_SEG_REST:   opHit = 10'h002; // [RQ10]
                `SMX_OP_LDT_SAVE:   opHit = 10'h004; // [RQ10]
                `SMX_OP_LDT_REST:   opHit = 10'h008; // [RQ10]
                `SMX_OP_TSK_SAVE:   opHit = 10'h010; // [RQ10]
                `SMX_OP_TSK_REST:   opHit = 10'h020; // [RQ10]
                `SMX_OP_SOFT_ENTRY: opHit = 10'h040; // [RQ11]
                `SMX_OP_HDR_READ:   opHit = 10'h080; // [RQ11]
                `SMX_OP_HDR_WRITE:  opHit = 10'h100; // [RQ11]
                `SMX_OP_RESUME:     opHit = 10'h200; // [RQ12]
                default:            opHit = 10'h000;
            endcase
        end
    end
endmodule

/* rtl/smx_mode_ctl.v */
`timescale 1ns/1ns
`include "smx_regs.vh"
// Summary of operation
// RQ1: save current and next instruction addresses
// RQ2: string I/O trap: both pointers equal
// RQ3: save I/O trap fields; resume skips data
// RQ4: save debug, flags, control zero registers
// RQ5: software-entry bit set only for soft entry
// RQ6: pointer bits 31:2, bit0 valid, bit1 reserved
// RQ7: region write or reset clears valid
// RQ8: invalid pointer reloads base plus size; the code adds region3End, not region3Size
// RQ9: handler writes pointer before nesting
// RQ10: decode descriptor save/restore opcodes 78-7D
// RQ11: decode soft entry, pointer read/write
// RQ12: resume leaves mode, restores header state
// RQ13: segment restore rejects code segment
// RQ14: privileged ops gated; otherwise invalid opcode
// RQ15: descriptor ops move 80 bits
// RQ16: pointer read/write move 32 bits
// RQ17: pin and soft entry enable conditions
// RQ18: management interrupt beats all others
// RQ19: entry forces reset values, code segment base
// RQ20: entry masks interrupts; one NMI latched
// RQ21: resume loads pointer from next field
// RQ22: handler adjusts next pointer before resume
module smx_mode_ctl #(
    parameter ADDR_W = 32,
    parameter DESC_W = `SMX_DESC_BITS
) (
    input  wire              core_clk,
    input  wire              reset,
    // chipset pin, active low, sampled synchronously
    input  wire              sysmgmtIrqPin_n,
    input  wire              nmiReq,
    input  wire              intrReq,
    // configuration
    input  wire [7:0]        configCtlOne,
    input  wire              nmiUnmaskBit,
    input  wire [3:0]        region3Size,
    input  wire [31:0]       region3Base,
    input  wire [31:0]       region3End,
    input  wire              region3Write,
    input  wire [1:0]        curPriv,
    // instruction issue
    input  wire              opValid,
    input  wire [7:0]        opPrefix,
    input  wire [7:0]        opByte,
    input  wire [2:0]        opSreg,
    input  wire [31:0]       opSrcData,
    input  wire [DESC_W-1:0] descIn,
    // core state at the boundary
    input  wire [31:0]       curIp,
    input  wire [31:0]       nextIp,
    input  wire [31:0]       dbgCtlIn,
    input  wire [31:0]       flagsIn,
    input  wire [31:0]       ctlZeroIn,
    input  wire              ioTrap,
    input  wire              ioRep,
    input  wire              ioWrite,
    input  wire [15:0]       ioPort,
    input  wire [3:0]        ioSize,
    input  wire [31:0]       ioData,
    input  wire [31:0]       ioIndex,
    input  wire              haltState,
    // header contents for resume
    input  wire [31:0]       hdrNextIp,
    input  wire [31:0]       hdrDbgCtl,
    input  wire [31:0]       hdrFlags,
    input  wire [31:0]       hdrCtlZero,
    // outputs
    output reg               sysmgmtMode_r,
    output reg  [31:0]       headerPtr_r,
    output reg               hdrSaveStb_r,
    output reg  [31:0]       hdrAddr_r,
    output reg  [31:0]       hdrCurIp_r,
    output reg  [31:0]       hdrNextIp_r,
    output reg  [31:0]       hdrDbgCtl_r,
    output reg  [31:0]       hdrFlags_r,
    output reg  [31:0]       hdrCtlZero_r,
    output reg  [7:0]        hdrBits_r,
    output reg  [15:0]       hdrIoPort_r,
    output reg  [3:0]        hdrIoSize_r,
    output reg  [31:0]       hdrIoData_r,
    output reg  [31:0]       hdrIoIndex_r,
    output reg               loadStb_r,
    output reg  [31:0]       loadIp_r,
    output reg  [31:0]       loadDbgCtl_r,
    output reg  [31:0]       loadFlags_r,
    output reg  [31:0]       loadCtlZero_r,
    output reg  [31:0]       csBase_r,
    output reg  [31:0]       csLimit_r,
    output reg               realMode_r,
    output reg               invalidOp_r,
    output reg               descMoveStb_r,
    output reg  [DESC_W-1:0] descOut_r,
    output reg  [31:0]       opResult_r,
    output reg               intrMasked_r,
    output reg               nmiMasked_r,
    output reg               nmiPending_r,
    output reg               nmiTake,
    output reg               intrTake
);
    localparam ST_RUN   = 2'h0;
    localparam ST_CHECK = 2'h1;
    localparam ST_SAVE  = 2'h2;
    localparam ST_FORCE = 2'h3;

    wire [9:0] opHit;
    reg  [1:0] state_r;
    reg  [1:0] state_nxt;
    reg        softCause_r;
    reg        pinPrev_r;
    reg        pinEvent_r;

    smx_op_decode uDecode (
        .prefixByte (opPrefix),
        .opByte     (opByte),
        .opHit      (opHit)
    );

    wire pinEn   = configCtlOne[`SMX_CC1_PIN_EN];
    wire accBit  = configCtlOne[`SMX_CC1_ACCESS];
    wire r3Sel   = configCtlOne[`SMX_CC1_REG3_SEL];
    wire sizeOk  = (region3Size != 4'h0);

    // pin and soft entry enable tables differ only in the access bit
    wire pinAllowed  = pinEn && !accBit && sizeOk && r3Sel;       // [RQ17]
    wire softAllowed = pinEn && accBit && sizeOk && r3Sel;        // [RQ17]
    // privileged ops outside soft entry
    wire privOk = sizeOk && (curPriv == 2'h0) && (accBit || sysmgmtMode_r)
                  && pinEn && r3Sel;                               // [RQ14]

    wire isSoft   = opValid && opHit[6];
    wire isPriv   = opValid && |{opHit[9:7], opHit[5:0]};
    wire csRest   = opHit[1] && ((opSreg == `SMX_SREG_CS) || (opSreg > `SMX_SREG_LAST));

    // falling edge of the pin
    wire pinFall  = pinPrev_r && !sysmgmtIrqPin_n;
    wire pinReq   = (pinEvent_r || pinFall) && pinAllowed;
    wire softReq  = isSoft && softAllowed && !sysmgmtMode_r;
    wire entryReq = (state_r == ST_RUN) && !sysmgmtMode_r && (pinReq || softReq);
    wire resumeOk = opValid && opHit[9] && privOk && sysmgmtMode_r && (state_r == ST_RUN);

    // one pin event is held while busy, serviced after resume
    always @(posedge core_clk) begin
        if (reset) begin
            pinPrev_r  <= 1'b1;
            pinEvent_r <= 1'b0;
        end else begin
            pinPrev_r <= sysmgmtIrqPin_n;
            if (pinFall && (sysmgmtMode_r || state_r != ST_RUN))
                pinEvent_r <= 1'b1;
            else if (entryReq && !softReq)
                pinEvent_r <= 1'b0;
        end
    end

    // management entry has priority over NMI and INTR
    always @* begin
        nmiTake  = 1'b0;
        intrTake = 1'b0;
        if (!entryReq && state_r == ST_RUN) begin                 // [RQ18]
            if ((nmiReq || nmiPending_r) && !nmiMasked_r)
                nmiTake = 1'b1;
            else if (intrReq && !intrMasked_r)
                intrTake = 1'b1;
        end
    end

    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_RUN:   if (entryReq) state_nxt = ST_CHECK;
            ST_CHECK: state_nxt = ST_SAVE;
            ST_SAVE:  state_nxt = ST_FORCE;
            ST_FORCE: state_nxt = ST_RUN;
            default:  state_nxt = ST_RUN;
        endcase
    end

    always @(posedge core_clk) begin
        if (reset) begin
            state_r       <= ST_RUN;
            sysmgmtMode_r <= 1'b0;
            softCause_r   <= 1'b0;
            headerPtr_r   <= `SMX_HLP_RESET;                       // [RQ7]
            hdrSaveStb_r  <= 1'b0;
            hdrAddr_r     <= 32'h00000000;
            hdrCurIp_r    <= 32'h00000000;
            hdrNextIp_r   <= 32'h00000000;
            hdrDbgCtl_r   <= 32'h00000000;
            hdrFlags_r    <= 32'h00000000;
            hdrCtlZero_r  <= 32'h00000000;
            hdrBits_r     <= 8'h00;
            hdrIoPort_r   <= 16'h0000;
            hdrIoSize_r   <= 4'h0;
            hdrIoData_r   <= 32'h00000000;
            hdrIoIndex_r  <= 32'h00000000;
            loadStb_r     <= 1'b0;
            loadIp_r      <= 32'h00000000;
            loadDbgCtl_r  <= 32'h00000000;
            loadFlags_r   <= 32'h00000000;
            loadCtlZero_r <= 32'h00000000;
            csBase_r      <= 32'h00000000;
            csLimit_r     <= 32'h00000000;
            realMode_r    <= 1'b0;
            invalidOp_r   <= 1'b0;
            descMoveStb_r <= 1'b0;
            descOut_r     <= {DESC_W{1'b0}};
            opResult_r    <= 32'h00000000;
            intrMasked_r  <= 1'b0;
            nmiMasked_r   <= 1'b0;
            nmiPending_r  <= 1'b0;
        end else begin
            state_r       <= state_nxt;
            hdrSaveStb_r  <= 1'b0;
            loadStb_r     <= 1'b0;
            invalidOp_r   <= 1'b0;
            descMoveStb_r <= 1'b0;

            if (entryReq)
                softCause_r <= softReq;

            // pointer: region write clears valid unless a reload or a pointer write in the same cycle wins
            if (state_r == ST_CHECK && !headerPtr_r[`SMX_HLP_VALID_BIT]) begin
                headerPtr_r <= ((region3Base + region3End) & `SMX_HLP_ADDR_MASK)
                               | (32'h00000001 << `SMX_HLP_VALID_BIT); // [RQ8]
            end else if (opValid && opHit[8] && privOk && state_r == ST_RUN) begin
                // reserved bit always reads back as zero
                headerPtr_r <= opSrcData & ~(32'h00000001 << `SMX_HLP_RSVD_BIT); // [RQ16] [RQ6]
            end else if (region3Write) begin
                headerPtr_r[`SMX_HLP_VALID_BIT] <= 1'b0;           // [RQ7]
            end

            if (state_r == ST_SAVE) begin
                hdrSaveStb_r <= 1'b1;
                hdrAddr_r    <= headerPtr_r & `SMX_HLP_ADDR_MASK;  // [RQ6]
                hdrCurIp_r   <= curIp;                             // [RQ1]
                // string I/O trap restarts, so both pointers match
                hdrNextIp_r  <= (ioTrap && ioRep) ? curIp : nextIp; // [RQ2] [RQ1]
                hdrDbgCtl_r  <= dbgCtlIn;                          // [RQ4]
                hdrFlags_r   <= flagsIn;                           // [RQ4]
                hdrCtlZero_r <= ctlZeroIn;                         // [RQ4]
                // bits: 0 soft 1 rep 2 write 3 halt, 7:4 zero
                hdrBits_r    <= {3'h0, 1'b0, haltState, ioTrap && ioWrite,
                                 ioTrap && ioRep, softCause_r};    // [RQ5] [RQ3]
                hdrIoPort_r  <= ioTrap ? ioPort : 16'h0000;        // [RQ3]
                hdrIoSize_r  <= ioTrap ? ioSize : 4'h0;            // [RQ3]
                hdrIoData_r  <= ioTrap ? ioData : 32'h00000000;    // [RQ3]
                hdrIoIndex_r <= ioTrap ? ioIndex : 32'h00000000;   // [RQ3]
            end

            if (state_r == ST_FORCE) begin
                sysmgmtMode_r <= 1'b1;
                loadStb_r     <= 1'b1;
                loadIp_r      <= 32'h00000000;
                loadCtlZero_r <= `SMX_CR0_RESET;                   // [RQ19]
                loadFlags_r   <= `SMX_FLAGS_RESET;                 // [RQ19]
                loadDbgCtl_r  <= `SMX_DBG_RESET;                   // [RQ19]
                csBase_r      <= region3Base;                      // [RQ19]
                csLimit_r     <= `SMX_CS_LIMIT;                    // [RQ19]
                realMode_r    <= 1'b1;                             // [RQ19]
                intrMasked_r  <= 1'b1;                             // [RQ20]
                nmiMasked_r   <= 1'b1;                             // [RQ20]
            end else if (sysmgmtMode_r && nmiUnmaskBit) begin
                nmiMasked_r <= 1'b0;                               // [RQ20]
            end

            // one masked NMI is held; set beats the take-clear
            if (nmiReq && nmiMasked_r)
                nmiPending_r <= 1'b1;                              // [RQ20]
            else if (nmiTake)
                nmiPending_r <= 1'b0;

            if (resumeOk) begin
                sysmgmtMode_r <= 1'b0;                             // [RQ12]
                loadStb_r     <= 1'b1;
                loadIp_r      <= hdrNextIp;                        // [RQ21]
                // trapped I/O data is not reloaded
                loadDbgCtl_r  <= hdrDbgCtl;                        // [RQ12] [RQ3]
                loadFlags_r   <= hdrFlags;                         // [RQ12]
                loadCtlZero_r <= hdrCtlZero;                       // [RQ12]
                realMode_r    <= 1'b0;
                intrMasked_r  <= 1'b0;
                nmiMasked_r   <= 1'b0;                             // [RQ20]
            end

            if (isPriv && state_r == ST_RUN) begin
                if (!privOk || (opHit[9] && !sysmgmtMode_r) || csRest) begin
                    invalidOp_r <= 1'b1;                           // [RQ14] [RQ13]
                end else if (|opHit[5:0]) begin
                    descMoveStb_r <= 1'b1;
                    descOut_r     <= descIn;                       // [RQ15]
                end else if (opHit[7]) begin
                    opResult_r <= headerPtr_r;                     // [RQ16]
                end
            end
            if (isSoft && !softAllowed)
                invalidOp_r <= 1'b1;                               // [RQ17]
        end
    end
endmodule

/* tb/smx_props.sv */
`timescale 1ns/1ns
`include "smx_regs.vh"
module smx_props (
    input wire        core_clk,
    input wire        reset,
    input wire [7:0]  configCtlOne,
    input wire [3:0]  region3Size,
    input wire [31:0] region3Base,
    input wire        region3Write,
    input wire [1:0]  curPriv,
    input wire        opValid,
    input wire [7:0]  opPrefix,
    input wire [7:0]  opByte,
    input wire [31:0] curIp,
    input wire [31:0] hdrNextIp,
    input wire        sysmgmtMode_r,
    input wire [31:0] headerPtr_r,
    input wire        hdrSaveStb_r,
    input wire [31:0] hdrAddr_r,
    input wire [31:0] hdrCurIp_r,
    input wire        loadStb_r,
    input wire [31:0] loadIp_r,
    input wire [31:0] loadCtlZero_r,
    input wire [31:0] csBase_r,
    input wire        realMode_r,
    input wire        invalidOp_r,
    input wire        intrMasked_r,
    input wire        nmiMasked_r
);
    wire mgmtOp = opValid && opPrefix == `SMX_OP_PREFIX;
    wire gateOk = region3Size != 4'h0 && curPriv == 2'h0 && configCtlOne[1] && configCtlOne[7];
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    a_save_ptr_ok: assert property (hdrSaveStb_r |-> headerPtr_r[0]
        && hdrAddr_r == (headerPtr_r & `SMX_HLP_ADDR_MASK)) else $error("bad header address");
    a_save_cur_ip: assert property (hdrSaveStb_r |-> hdrCurIp_r == curIp)
        else $error("current ip not saved");
    a_ptr_rsvd_zero: assert property (!headerPtr_r[1]) else $error("pointer bit 1 set");
    a_r3w_clears: assert property (region3Write && !opValid |=> !headerPtr_r[0])
        else $error("range write left pointer valid");
    a_entry_force: assert property ($rose(sysmgmtMode_r) |-> loadStb_r && realMode_r
        && loadCtlZero_r == `SMX_CR0_RESET && csBase_r == region3Base) else $error("entry state");
    a_save_then_mask: assert property (hdrSaveStb_r && !sysmgmtMode_r |=> sysmgmtMode_r
        && intrMasked_r && nmiMasked_r) else $error("entry did not mask");
    a_resume_ip: assert property (mgmtOp && opByte == `SMX_OP_RESUME && gateOk && sysmgmtMode_r
        |=> loadStb_r && !sysmgmtMode_r && loadIp_r == $past(hdrNextIp)) else $error("resume");
    a_priv_refuse: assert property (mgmtOp && opByte >= 8'h78 && opByte <= 8'h7D
        && curPriv != 2'h0 |=> invalidOp_r) else $error("privileged op not refused");
endmodule
bind smx_mode_ctl smx_props u_props (
    .core_clk(core_clk), .reset(reset), .configCtlOne(configCtlOne), .region3Size(region3Size),
    .region3Base(region3Base), .region3Write(region3Write), .curPriv(curPriv),
    .opValid(opValid), .opPrefix(opPrefix), .opByte(opByte), .curIp(curIp),
    .hdrNextIp(hdrNextIp), .sysmgmtMode_r(sysmgmtMode_r), .headerPtr_r(headerPtr_r),
    .hdrSaveStb_r(hdrSaveStb_r), .hdrAddr_r(hdrAddr_r), .hdrCurIp_r(hdrCurIp_r),
    .loadStb_r(loadStb_r), .loadIp_r(loadIp_r), .loadCtlZero_r(loadCtlZero_r),
    .csBase_r(csBase_r), .realMode_r(realMode_r), .invalidOp_r(invalidOp_r),
    .intrMasked_r(intrMasked_r), .nmiMasked_r(nmiMasked_r)
);

/* tb/smx_chipset_model.sv */
`timescale 1ns/1ns
module smx_chipset_model (
    input  wire       core_clk,
    input  wire       fire,
    input  wire [3:0] lowLen,
    output reg        irqPin_n
);
    reg [3:0] cnt_r = 4'h0;
    initial irqPin_n = 1'b1;
    // pulled-up line: released pin reads high, one falling edge per request
    always @(posedge core_clk) begin
        if (fire && cnt_r == 4'h0) begin
            cnt_r <= lowLen;
            irqPin_n <= #5 1'b0;
        end else if (cnt_r != 4'h0) begin
            cnt_r <= cnt_r - 4'h1;
            if (cnt_r == 4'h1) irqPin_n <= #5 1'b1;
        end
    end
endmodule

/* tb/tb.sv */
`timescale 1ns/1ns
`include "smx_regs.vh"
module tb;
    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] cur;
        logic [31:0] nxt;
        logic [7:0]  bits;
        logic [15:0] port;
    } smx_save_t;
    logic        core_clk, reset, fire, nmiReq, intrReq, nmiUnmask, r3Write, opValid;
    logic        ioTrap, ioRep, ioWrite, haltState;
    logic [7:0]  cc1, opByte;
    logic [3:0]  r3Size;
    logic [2:0]  opSreg;
    logic [1:0]  curPriv;
    logic [15:0] ioPort;
    logic [79:0] descIn;
    logic [31:0] r3Base, r3End, opSrc, curIp, nextIp, hdrNextIp, ptrExp;
    wire         pin_n, mode, saveStb, loadStb, invOp, nmiPend, nmiTk, descStb;
    wire  [3:0]  ioSz;
    wire  [7:0]  hdrBits;
    wire  [15:0] hdrPort;
    wire  [79:0] descOut;
    wire  [31:0] ptr, hdrAddr, hdrCur, hdrNxt, loadIp, opResult, hdrDbg, hdrFlg, hdrCz;
    wire  [31:0] ioDat, ioIdx, ldDbg, ldFlg, csLim;
    logic [79:0] qDesc[$];
    int          fails, total_checks, cycles;
    smx_save_t   qSave[$];
    logic [31:0] qLoad[$];
    logic        qInv[$];
    logic [7:0]  privOps[9] = '{8'h78, 8'h79, 8'h7A, 8'h7B, 8'h7C, 8'h7D, 8'h36, 8'h37, 8'hAA};
    smx_chipset_model u_chipset (.core_clk(core_clk), .fire(fire), .lowLen(4'h3), .irqPin_n(pin_n));
    smx_mode_ctl dut (
        .core_clk(core_clk), .reset(reset), .sysmgmtIrqPin_n(pin_n), .nmiReq(nmiReq),
        .intrReq(intrReq), .configCtlOne(cc1), .nmiUnmaskBit(nmiUnmask), .region3Size(r3Size),
        .region3Base(r3Base), .region3End(r3End), .region3Write(r3Write), .curPriv(curPriv),
        .opValid(opValid), .opPrefix(8'h0F), .opByte(opByte), .opSreg(opSreg),
        .opSrcData(opSrc), .descIn(descIn), .curIp(curIp), .nextIp(nextIp), .dbgCtlIn(opSrc),
        .flagsIn(nextIp), .ctlZeroIn(curIp), .ioTrap(ioTrap), .ioRep(ioRep), .ioWrite(ioWrite),
        .ioPort(ioPort), .ioSize(4'h3), .ioData(opSrc), .ioIndex(nextIp), .haltState(haltState),
        .hdrNextIp(hdrNextIp), .hdrDbgCtl(opSrc), .hdrFlags(curIp), .hdrCtlZero(nextIp),
        .sysmgmtMode_r(mode), .headerPtr_r(ptr), .hdrSaveStb_r(saveStb), .hdrAddr_r(hdrAddr),
        .hdrCurIp_r(hdrCur), .hdrNextIp_r(hdrNxt), .hdrDbgCtl_r(hdrDbg), .hdrFlags_r(hdrFlg),
        .hdrCtlZero_r(hdrCz), .hdrBits_r(hdrBits), .hdrIoPort_r(hdrPort), .hdrIoSize_r(ioSz),
        .hdrIoData_r(ioDat), .hdrIoIndex_r(ioIdx), .loadStb_r(loadStb), .loadIp_r(loadIp),
        .loadDbgCtl_r(ldDbg), .loadFlags_r(ldFlg), .loadCtlZero_r(), .csBase_r(),
        .csLimit_r(csLim), .realMode_r(), .invalidOp_r(invOp), .descMoveStb_r(descStb),
        .descOut_r(descOut), .opResult_r(opResult), .intrMasked_r(), .nmiMasked_r(),
        .nmiPending_r(nmiPend), .nmiTake(nmiTk), .intrTake()
    );
    always #25 core_clk = ~core_clk;
    task automatic check(input logic [119:0] seen, input logic [119:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value at %0t: saw %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic op(input logic [7:0] b, input logic [2:0] s, input logic inv);
        @(posedge core_clk) #5;
        opValid = 1;
        opByte = b;
        opSreg = s;
        descIn = {$urandom, $urandom, 16'($urandom)};
        if (inv) qInv.push_back(1'b1);
        if (!inv && b >= 8'h78 && b <= 8'h7D) qDesc.push_back(descIn);
        @(posedge core_clk) #5;
        opValid = 0;
        @(posedge core_clk) #5;
    endtask
    task automatic waitMode(input logic want);
        for (int n = 0; n < 20 && mode !== want; n++) @(posedge core_clk) #5;
        check(mode, want);
    endtask
    task automatic pinEntry(input smx_save_t e);
        qSave.push_back(e);
        fire = 1;
        @(posedge core_clk) #5;
        fire = 0;
        @(negedge core_clk) check(nmiTk, 1'b0);
        waitMode(1);
    endtask
    task automatic resume(input logic [31:0] ip, input string name);
        hdrNextIp = ip;
        qLoad.push_back(ip);
        op(8'hAA, 3'h0, 0);
        check(mode, 0);
        $display("test %s done", name);
    endtask
    always @(negedge core_clk) begin
        if (!reset && saveStb === 1'b1) begin
            check({hdrAddr, hdrCur, hdrNxt, hdrBits, hdrPort}, qSave.pop_front());
            check({hdrDbg, hdrFlg, hdrCz}, {opSrc, nextIp, curIp});
            check({ioSz, ioDat, ioIdx}, ioTrap ? {4'h3, opSrc, nextIp} : 68'h0);
        end
        if (!reset && loadStb === 1'b1 && mode === 1'b0)
            check({loadIp, ldDbg, ldFlg}, {qLoad.pop_front(), opSrc, curIp});
        if (!reset && loadStb === 1'b1 && mode === 1'b1)
            check({ldDbg, ldFlg, csLim}, {`SMX_DBG_RESET, `SMX_FLAGS_RESET, `SMX_CS_LIMIT});
        if (!reset && descStb === 1'b1)
            check(descOut, qDesc.pop_front());
        if (!reset && invOp === 1'b1)
            check(invOp, qInv.size() > 0 ? qInv.pop_front() : 1'b0);
    end
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 3000) begin
            fails++;
            print_verdict();
        end
    end
    initial begin
        {core_clk, fire, nmiReq, intrReq, nmiUnmask, r3Write, opValid} = 0;
        {ioTrap, ioRep, ioWrite, haltState, opByte, opSreg, curPriv, ioPort, descIn} = 0;
        {opSrc, hdrNextIp, fails, total_checks, cycles} = 0;
        reset = 1;
        void'($urandom(25));
        cc1 = 8'h82;
        r3Size = 4'h3;
        r3Base = 32'h000A0000;
        r3End = ($urandom & 32'h0000F000) + 32'h00001000;
        curIp = $urandom;
        nextIp = $urandom;
        ptrExp = r3Base + r3End;
        repeat (10) @(posedge core_clk);
        #5 reset = 0;
        nmiReq = 1;
        pinEntry({ptrExp & 32'hFFFFFFFC, curIp, nextIp, 8'h00, 16'h0000});
        // the mask lands with the mode bit, the latch one edge later
        @(posedge core_clk) #5;
        check(nmiPend, 1);
        nmiReq = 0;
        op(8'h36, 3'h0, 0);
        check(opResult, ptrExp | 32'h1);
        opSrc = $urandom | 32'h1;
        op(8'h37, 3'h0, 0);
        op(8'h36, 3'h0, 0);
        check(opResult, opSrc & 32'hFFFFFFFD);
        for (int b = 8'h78; b <= 8'h7D; b++) op(8'(b), 3'h3, 0);
        op(8'h79, 3'h1, 1);
        op(8'h79, 3'h6, 1);
        resume($urandom, "pin entry");
        cc1 = 8'h86;
        curIp = $urandom;
        qSave.push_back({opSrc & 32'hFFFFFFFC, curIp, nextIp, 8'h01, 16'h0000});
        op(8'h38, 3'h0, 0);
        waitMode(1);
        resume($urandom, "soft entry");
        cc1 = 8'h82;
        op(8'h38, 3'h0, 1);
        op(8'hAA, 3'h0, 1);
        cc1 = 8'h86;
        curPriv = 2'h3;
        foreach (privOps[i]) op(privOps[i], 3'h3, 1);
        curPriv = 2'h0;
        r3Size = 4'h0;
        op(8'h36, 3'h0, 1);
        r3Size = 4'h3;
        $display("test refusals done");
        cc1 = 8'h82;
        r3Write = 1;
        @(posedge core_clk) #5;
        r3Write = 0;
        {ioTrap, ioRep, ioWrite, haltState} = 4'hF;
        ioPort = 16'($urandom);
        pinEntry({ptrExp & 32'hFFFFFFFC, curIp, curIp, 8'h0E, ioPort});
        {ioTrap, ioRep, ioWrite, haltState} = 4'h0;
        resume(curIp, "io trap entry");
        cc1 = 8'h86;
        fire = 1;
        @(posedge core_clk) #5;
        fire = 0;
        repeat (10) @(posedge core_clk) #5;
        check(mode, 0);
        check(qSave.size() + qLoad.size() + qInv.size() + qDesc.size(), 0);
        print_verdict();
    end
endmodule
